// ===== ccu_top.sv
// Purpose: Capture/compare unit against a shared 16-bit timer.
// Assumes: Register port strobes are single-cycle, never both.
// Notes:   Pin direction is owned by the port logic outside.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module ccu_top (
   // Clock, reset, enable
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   input  wire logic                     ce,
   // Register port
   input  wire ccu_pkg::ccu_bus_req_type bus_req,
   output logic [7:0]                    rd_data,
   // Power and timer source
   input  wire logic                     sleep,
   input  wire logic                     ext_clk_in,
   // Converter hookup
   input  wire logic                     adc_enable,
   output logic                          adc_start,
   // Module pin
   input  wire logic                     pin_in,
   output logic                          pin_out,
   output logic                          pin_oe_n,
   // Events
   output logic                          special_trig,
   output logic                          irq
);
   // Software registers
   logic [7:0]  control_ff;      // Control register
   logic [15:0] value_ff;        // Value register pair
   logic [1:0]  tctrl_ff;        // Timer run and source
   logic [1:0]  status_ff;       // Sticky event bits
   logic [1:0]  mask_ff;         // Interrupt mask

   // Compare state
   logic        out_latch_ff;    // Compare output latch
   logic        match_prev_ff;   // Equality seen last cycle
   logic        trig_pend_ff;    // Timer reset awaiting a tick

   // Output flops
   logic [7:0]  rd_data_ff;      // Read data, one cycle late
   logic        pin_oe_n_ff;     // Low while driving the pin
   logic        trig_ff;         // Trigger pulse
   logic        adc_start_ff;    // Converter start pulse
   logic        irq_ff;          // Interrupt level

   // Decode and datapath
   logic [3:0]           mode;        // Operating mode field
   ccu_pkg::ccu_action_type action;   // Decoded compare action
   logic                 drives_pin;  // Mode owns the pin
   logic                 equal;       // Timer equals value
   logic                 fire;        // Entry into equality
   logic                 cap_evt;     // Capture event
   logic [15:0]          count;       // Timer count
   logic                 tick;        // Timer advance
   logic                 wrap;        // Timer overflow
   logic                 tload;       // Software timer load
   logic [15:0]          tload_val;   // Timer load value
   logic                 clear_req;   // Trigger reset request
   logic                 wr_ctrl;     // Control write
   logic                 wr_vlo;      // Value low write
   logic                 wr_vhi;      // Value high write
   logic                 wr_tlo;      // Timer low write
   logic                 wr_thi;      // Timer high write
   logic                 wr_tctl;     // Timer control write
   logic                 wr_stat;     // Status write
   logic                 wr_mask;     // Mask write
   logic [1:0]           nxt_status;  // Next sticky bits
   logic [1:0]           set_bits;    // Events this cycle
   logic [7:0]           rd_mux;      // Read selection

   assign mode    = control_ff[3:0];
   assign wr_ctrl = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_CONTROL);
   assign wr_vlo  = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_VALUE_LOW);
   assign wr_vhi  = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_VALUE_HIGH);
   assign wr_tlo  = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_TIMER_LOW);
   assign wr_thi  = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_TIMER_HIGH);
   assign wr_tctl = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_TIMER_CTRL);
   assign wr_stat = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_IRQ_STATUS);
   assign wr_mask = bus_req.wr && (bus_req.addr == ccu_pkg::OFS_IRQ_MASK);

   // Mode field to compare action
   always_comb begin
      case (mode)
         ccu_pkg::MODE_CMP_TOGGLE: action = ccu_pkg::ACT_TOGGLE;
         ccu_pkg::MODE_CMP_SET:    action = ccu_pkg::ACT_SET;
         ccu_pkg::MODE_CMP_CLEAR:  action = ccu_pkg::ACT_CLEAR;
         ccu_pkg::MODE_CMP_TRIG:   action = ccu_pkg::ACT_TRIG;
         ccu_pkg::MODE_CMP_FLAG:   action = ccu_pkg::ACT_FLAG;
         default:                  action = ccu_pkg::ACT_NONE;
      endcase
   end

   // Trigger and flag-only modes never take the pin
   assign drives_pin = (action == ccu_pkg::ACT_TOGGLE) ||
                       (action == ccu_pkg::ACT_SET) ||
                       (action == ccu_pkg::ACT_CLEAR);          // [R13] [R14]

   // Full 16-bit equality, looked at on every cycle the timer may move
   assign equal = (action != ccu_pkg::ACT_NONE) && (count == value_ff); // [R5]
   // A standing match would otherwise retrigger every cycle
   assign fire  = equal && !match_prev_ff;                      // [R16]

   // Timer register writes keep the other byte
   assign tload     = wr_tlo || wr_thi;
   assign tload_val = wr_tlo ? {count[15:8], bus_req.wdata}
                             : {bus_req.wdata, count[7:0]};
   // Reset lands on the next timer tick, the match cycle included
   // A value change that ends the match drops a pending reset at once
   assign clear_req = (trig_pend_ff && equal) || (fire && (action == ccu_pkg::ACT_TRIG)); // [R14]

   // Shared timer
   ccu_timer #(
      .WIDTH (16)
   ) u_timer (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .ce         (ce),
      .run        (tctrl_ff[ccu_pkg::TCTRL_RUN_BIT]),
      .src_ext    (tctrl_ff[ccu_pkg::TCTRL_EXT_BIT]),
      .sleep      (sleep),
      .ext_clk_in (ext_clk_in),
      .load       (tload),
      .load_val   (tload_val),
      .clear_req  (clear_req),
      .count      (count),
      .tick       (tick),
      .wrap       (wrap)
   );

   // Pin event detector; runs in sleep since only the timer stalls
   ccu_capture_detect u_detect (
      .clock   (clock),
      .sys_rst (sys_rst),
      .ce      (ce),
      .mode    (mode),
      .pin_in  (pin_in),
      .capture (cap_evt)
   );

   // Control register; every bit stored, upper bits feed only readback
   always_ff @(posedge clock) begin
      if (sys_rst) control_ff <= ccu_pkg::CONTROL_RST;
      else if (ce && wr_ctrl) control_ff <= bus_req.wdata;
   end

   // Value pair; a capture beats a same-cycle software write
   always_ff @(posedge clock) begin
      if (sys_rst) value_ff <= ccu_pkg::VALUE_RST;
      else if (ce) begin
         if (cap_evt) value_ff <= count;                        // [R15] [R3]
         else if (wr_vlo) value_ff[7:0] <= bus_req.wdata;
         else if (wr_vhi) value_ff[15:8] <= bus_req.wdata;
      end
   end

   // Timer control; only two bits exist
   always_ff @(posedge clock) begin
      if (sys_rst) tctrl_ff <= ccu_pkg::TCTRL_RST;
      else if (ce && wr_tctl) tctrl_ff <= bus_req.wdata[1:0];   // [R12]
   end

   // Match history for once-per-entry firing
   always_ff @(posedge clock) begin
      if (sys_rst) match_prev_ff <= 1'b0;
      else if (ce) match_prev_ff <= equal;                      // [R16]
   end

   // Compare output latch; not the port data latch
   always_ff @(posedge clock) begin
      if (sys_rst) out_latch_ff <= 1'b0;
      else if (ce) begin
         if (wr_ctrl && (bus_req.wdata == 8'h00)) out_latch_ff <= 1'b0; // [R9]
         else if (fire) begin
            case (action)
               ccu_pkg::ACT_TOGGLE: out_latch_ff <= !out_latch_ff;      // [R6]
               ccu_pkg::ACT_SET:    out_latch_ff <= 1'b1;               // [R6]
               ccu_pkg::ACT_CLEAR:  out_latch_ff <= 1'b0;               // [R6]
               default:             out_latch_ff <= out_latch_ff;
            endcase
         end
      end
   end

   // Pin enable; the port direction bit outside still has the last word
   always_ff @(posedge clock) begin
      if (sys_rst) pin_oe_n_ff <= 1'b1;
      else if (ce) pin_oe_n_ff <= !drives_pin;                  // [R13]
   end

   // Trigger and converter start pulses
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         trig_ff      <= 1'b0;
         adc_start_ff <= 1'b0;
      end else if (ce) begin
         trig_ff      <= fire && (action == ccu_pkg::ACT_TRIG);               // [R14]
         adc_start_ff <= fire && (action == ccu_pkg::ACT_TRIG) && adc_enable; // [R14]
      end
   end

   // Pending timer reset; dropped if the match goes away before the tick
   always_ff @(posedge clock) begin
      if (sys_rst) trig_pend_ff <= 1'b0;
      else if (ce) begin
         if (tick || !equal) trig_pend_ff <= 1'b0;
         else if (fire && (action == ccu_pkg::ACT_TRIG)) trig_pend_ff <= 1'b1; // [R14]
      end
   end

   // Sticky events; a set in the clearing cycle wins
   assign set_bits   = {wrap, fire || cap_evt};                 // [R7]
   assign nxt_status = (status_ff & ~(wr_stat ? bus_req.wdata[1:0] : 2'h0))
                       | set_bits;

   // Status and mask registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_ff <= ccu_pkg::IRQ_RST;
         mask_ff   <= ccu_pkg::IRQ_RST;
      end else if (ce) begin
         status_ff <= nxt_status;                               // [R7]
         if (wr_mask) mask_ff <= bus_req.wdata[1:0] & ccu_pkg::IRQ_BITS; // [R12]
      end
   end

   // Interrupt level from the next status, so it tracks the flags exactly
   always_ff @(posedge clock) begin
      if (sys_rst) irq_ff <= 1'b0;
      else if (ce) irq_ff <= |(nxt_status & (wr_mask ? bus_req.wdata[1:0] : mask_ff));
   end

   // Read selection; absent bits and offsets read zero
   always_comb begin
      case (bus_req.addr)
         ccu_pkg::OFS_CONTROL:    rd_mux = control_ff;
         ccu_pkg::OFS_VALUE_LOW:  rd_mux = value_ff[7:0];
         ccu_pkg::OFS_VALUE_HIGH: rd_mux = value_ff[15:8];
         ccu_pkg::OFS_TIMER_LOW:  rd_mux = count[7:0];
         ccu_pkg::OFS_TIMER_HIGH: rd_mux = count[15:8];
         ccu_pkg::OFS_TIMER_CTRL: rd_mux = {6'h00, tctrl_ff};  // [R12]
         ccu_pkg::OFS_IRQ_STATUS: rd_mux = {6'h00, status_ff}; // [R12]
         ccu_pkg::OFS_IRQ_MASK:   rd_mux = {6'h00, mask_ff};   // [R12]
         default:                 rd_mux = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) rd_data_ff <= 8'h00;
      else if (ce) rd_data_ff <= bus_req.rd ? rd_mux : 8'h00;
   end

   // Outputs straight from flops
   assign rd_data      = rd_data_ff;
   assign pin_out      = out_latch_ff;
   assign pin_oe_n     = pin_oe_n_ff;
   assign special_trig = trig_ff;
   assign adc_start    = adc_start_ff;
   assign irq          = irq_ff;

   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence s_trig_fire;
      ce && fire && (action == ccu_pkg::ACT_TRIG);
   endsequence
   sequence s_trig_out;
      trig_ff && (adc_start_ff == $past(adc_enable)) && pin_oe_n_ff;
   endsequence
   sequence s_fire_hold;
      (ce && fire) ##1 (ce && equal);
   endsequence

   property p_match_flag;
      (ce && equal && !match_prev_ff && !wr_stat) |=> status_ff[ccu_pkg::IRQ_EVT_BIT];
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match not flagged"); // [R5]

   property p_set_act;
      (ce && fire && (action == ccu_pkg::ACT_SET) && !wr_ctrl)
         |=> pin_out && status_ff[ccu_pkg::IRQ_EVT_BIT];
   endproperty
   a_set_act: assert property (p_set_act) else $error("set action wrong"); // [R7]

   property p_toggle;
      (ce && fire && (action == ccu_pkg::ACT_TOGGLE) && !wr_ctrl)
         |=> pin_out != $past(pin_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle missed"); // [R6]

   property p_once;
      s_fire_hold |-> !fire;
   endproperty
   a_once: assert property (p_once) else $error("match fired twice"); // [R16]

   property p_zero_ctrl;
      (ce && wr_ctrl && (bus_req.wdata == 8'h00)) |=> !pin_out ##1 !pin_out;
   endproperty
   a_zero_ctrl: assert property (p_zero_ctrl) else $error("latch not cleared"); // [R9]

   property p_flag_pin;
      (ce && (action == ccu_pkg::ACT_FLAG)) |=> pin_oe_n;
   endproperty
   a_flag_pin: assert property (p_flag_pin) else $error("flag mode drove pin"); // [R13]

   property p_trig;
      s_trig_fire |=> s_trig_out ##1 !trig_ff;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger pulse wrong"); // [R14]

   property p_capture;
      (ce && cap_evt) |=> (value_ff == $past(count)) && status_ff[ccu_pkg::IRQ_EVT_BIT];
   endproperty
   a_capture: assert property (p_capture) else $error("capture lost"); // [R15]

   property p_sleep_cap;
      (ce && sleep && tctrl_ff[ccu_pkg::TCTRL_EXT_BIT] && cap_evt)
         |=> value_ff == $past(count);
   endproperty
   a_sleep_cap: assert property (p_sleep_cap) else $error("sleep capture lost"); // [R3]

   property p_rd_zero;
      (ce && bus_req.rd && (bus_req.addr == ccu_pkg::OFS_TIMER_CTRL))
         |=> rd_data[7:2] == 6'h00;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("reserved bits set"); // [R12]
endmodule

// ===== ccu_pkg.sv
// Purpose: Shared constants and types for the capture/compare unit.
// Assumes: One 8-bit register port; 16-bit shared timer.
// Notes:   Function list follows.
// Function
// (R1) Instruction-clocked timer holds during sleep
// (R2) Timer resumes from held value after wake
// (R3) Capture works in sleep with external clock
// (R4) Timer source: instruction clock or external
// (R5) Compare value checked against timer for equality
// (R6) Mode field picks toggle, set, clear, trigger, flag
// (R7) Match flag set with the match action
// (R8) Software makes pin an output first
// (R9) Zero control write clears compare output latch
// (R10) Software avoids asynchronous counter mode
// (R11) Software avoids raw oscillator timer clock
// (R12) Unimplemented bits read zero, ignore writes
// (R13) Flag-only mode leaves the pin alone
// (R14) Trigger pulse, converter start, timer reset
// (R15) Selected pin event captures timer count
// (R16) Match fires once per entry into equality
package ccu_pkg;
   // Register port request
   typedef struct packed {
      logic       wr;     // Write strobe
      logic       rd;     // Read strobe
      logic [3:0] addr;   // Register offset
      logic [7:0] wdata;  // Write data
   } ccu_bus_req_type;

   // Register offsets
   localparam logic [3:0] OFS_CONTROL    = 4'h0;
   localparam logic [3:0] OFS_VALUE_LOW  = 4'h1;
   localparam logic [3:0] OFS_VALUE_HIGH = 4'h2;
   localparam logic [3:0] OFS_TIMER_LOW  = 4'h3;
   localparam logic [3:0] OFS_TIMER_HIGH = 4'h4;
   localparam logic [3:0] OFS_TIMER_CTRL = 4'h5;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
   localparam logic [3:0] OFS_IRQ_MASK   = 4'h7;

   // Field positions and implemented-bit masks
   localparam int         TCTRL_RUN_BIT = 0;
   localparam int         TCTRL_EXT_BIT = 1;
   localparam logic [7:0] TCTRL_BITS    = 8'h03;
   localparam int         IRQ_EVT_BIT   = 0;
   localparam int         IRQ_OVF_BIT   = 1;
   localparam logic [1:0] IRQ_BITS      = 2'h3;

   // Reset values
   localparam logic [7:0]  CONTROL_RST = 8'h00;
   localparam logic [15:0] VALUE_RST   = 16'h0000;
   localparam logic [1:0]  TCTRL_RST   = 2'h0;
   localparam logic [1:0]  IRQ_RST     = 2'h0;

   // Operating mode field encodings
   localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET    = 4'h8;
   localparam logic [3:0] MODE_CMP_CLEAR  = 4'h9;
   localparam logic [3:0] MODE_CMP_FLAG   = 4'hA;
   localparam logic [3:0] MODE_CMP_TRIG   = 4'hB;

   // Capture prescaler terminal counts
   localparam logic [3:0] PRESC4_LAST  = 4'h3;
   localparam logic [3:0] PRESC16_LAST = 4'hF;

   // Decoded compare action
   typedef enum logic [2:0] {
      ACT_NONE, ACT_TOGGLE, ACT_SET, ACT_CLEAR, ACT_TRIG, ACT_FLAG
   } ccu_action_type;
endpackage

// ===== ccu_timer.sv
// Purpose: Shared 16-bit timer with selectable clock source.
// Assumes: External clock input is synchronous to clock.
// Notes:   A trigger reset replaces the next increment.
`timescale 1ns/1ps
module ccu_timer #(
   parameter int WIDTH = 16
) (
   // Clock and control
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   // Source and sleep
   input  wire logic             run,
   input  wire logic             src_ext,
   input  wire logic             sleep,
   input  wire logic             ext_clk_in,
   // Software load and trigger reset
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_val,
   input  wire logic             clear_req,
   // State out
   output logic      [WIDTH-1:0] count,
   output logic                  tick,
   output logic                  wrap
);
   logic             ext_prev_ff;  // Last external clock level
   logic [WIDTH-1:0] count_ff;     // Timer count

   // External clock edge history
   always_ff @(posedge clock) begin
      if (sys_rst) ext_prev_ff <= 1'b0;
      else if (ce) ext_prev_ff <= ext_clk_in;
   end

   // Only two sources; instruction clock stops in sleep, external does not
   assign tick = run && (src_ext ? (ext_clk_in && !ext_prev_ff) : !sleep); // [R1] [R3] [R4]
   assign wrap = tick && !clear_req && (count_ff == {WIDTH{1'b1}});
   assign count = count_ff;

   // Count; no reload on wake, so the held value simply continues
   always_ff @(posedge clock) begin
      if (sys_rst) count_ff <= '0;
      else if (ce) begin
         if (load) count_ff <= load_val;
         else if (tick && clear_req) count_ff <= '0;           // [R14]
         else if (tick) count_ff <= count_ff + 1'b1;           // [R2]
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_sleep_hold;
      (ce && sleep && run && !src_ext && !load) |=> count_ff == $past(count_ff);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("timer moved in sleep"); // [R1]
   property p_wake_resume;
      (ce && $fell(sleep) && run && !src_ext && !load && !clear_req)
         |=> count_ff == $past(count_ff) + 1'b1;
   endproperty
   a_wake_resume: assert property (p_wake_resume) else $error("timer lost state"); // [R2]
endmodule

// ===== ccu_capture_detect.sv
// Purpose: Pin event detector with capture prescaler.
// Assumes: Pin input is synchronous to clock.
// Notes:   Prescaler clears outside capture modes.
`timescale 1ns/1ps
module ccu_capture_detect (
   // Clock and control
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       ce,
   // Mode and pin
   input  wire logic [3:0] mode,
   input  wire logic       pin_in,
   // Event out
   output logic            capture
);
   logic       pin_prev_ff;  // Previous pin level
   logic [3:0] presc_ff;     // Rising edge prescaler
   logic       rise;         // Rising edge seen
   logic       fall;         // Falling edge seen
   logic       cap_mode;     // Any capture mode

   assign rise     = pin_in && !pin_prev_ff;
   assign fall     = !pin_in && pin_prev_ff;
   assign cap_mode = (mode[3:2] == ccu_pkg::MODE_CAP_FALL[3:2]);

   // Pin history
   always_ff @(posedge clock) begin
      if (sys_rst) pin_prev_ff <= 1'b0;
      else if (ce) pin_prev_ff <= pin_in;
   end

   // Prescaler; a prescale switch without turning off may miscount
   always_ff @(posedge clock) begin
      if (sys_rst) presc_ff <= 4'h0;
      else if (ce) begin
         if (!cap_mode) presc_ff <= 4'h0;
         else if (rise) presc_ff <= presc_ff + 4'h1;
      end
   end

   // Event selection per mode
   always_comb begin
      case (mode)
         ccu_pkg::MODE_CAP_FALL:   capture = fall;                        // [R15]
         ccu_pkg::MODE_CAP_RISE:   capture = rise;                        // [R15]
         ccu_pkg::MODE_CAP_RISE4:
            capture = rise && (presc_ff[1:0] == ccu_pkg::PRESC4_LAST[1:0]); // [R15]
         ccu_pkg::MODE_CAP_RISE16:
            capture = rise && (presc_ff == ccu_pkg::PRESC16_LAST);          // [R15]
         default:                  capture = 1'b0;
      endcase
   end
endmodule

// ===== ccu_far_model.sv
// Purpose: Far side of the unit: external timer clock and event pin.
// Assumes: Bench requests change just after a rising clock edge.
// Notes:   Timer clock rests low between requested pulses.
`timescale 1ns/1ps
module ccu_far_model (
   // Clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // Requests from the bench
   input  wire logic pulse_req,
   input  wire logic pin_req,
   // Lines into the unit
   output logic      ext_clk_in,
   output logic      pin_in
);
   // Edge-aligned pulses, never a raw oscillator: keeps counting synchronous
   always_ff @(posedge clock) begin
      ext_clk_in <= sys_rst ? 1'b0 : pulse_req;
      pin_in     <= sys_rst ? 1'b0 : pin_req;
   end
endmodule

// ===== ccu_top_tb_top.sv
// Purpose: Self-checking bench for the capture/compare unit.
// Assumes: Read results are checked from a queue of expected bytes.
// Notes:   Compare runs start from timer 0x0110 against value 0x0120.
`timescale 1ns/1ps
module ccu_top_tb_top;
   logic                     clock     = 1'b0;
   logic                     sys_rst   = 1'b1;
   logic                     sleep     = 1'b0;
   logic                     pulse_req = 1'b0;
   logic                     pin_req   = 1'b0;
   logic                     adc_en    = 1'b1;
   ccu_pkg::ccu_bus_req_type bus_req   = '0;
   logic [7:0]               rd_data;
   logic                     ext_clk_in, pin_in, adc_start, pin_out, pin_oe_n;
   logic                     special_trig, irq;
   logic [7:0]               exp_q[$];   // Expected read bytes, oldest first
   logic                     rd_seen   = 1'b0;
   int                       n_errors  = 0;
   int                       cmp_count = 0;
   int                       trig_cnt  = 0;
   int                       adc_cnt   = 0;
   int                       seed      = 39379;
   logic [7:0]               rnd;

   // 50 MHz clock
   always #10 clock = ~clock;

   ccu_top dut_u (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .bus_req(bus_req),
      .rd_data(rd_data), .sleep(sleep), .ext_clk_in(ext_clk_in), .adc_enable(adc_en),
      .adc_start(adc_start), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .special_trig(special_trig), .irq(irq));
   ccu_far_model far_u (.clock(clock), .sys_rst(sys_rst), .pulse_req(pulse_req),
      .pin_req(pin_req), .ext_clk_in(ext_clk_in), .pin_in(pin_in));

   // Single comparison point
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Register write and read, one-cycle strobes
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      bus_req <= '{1'b0, 1'b1, a, 8'h00};
      exp_q.push_back(e);
      @(posedge clock);
      bus_req <= '0;
   endtask

   // Watcher: read data stand only in the cycle after the strobe
   always @(posedge clock) begin
      if (rd_seen) check("rd_data", rd_data, exp_q.pop_front());
      rd_seen <= bus_req.rd;
      trig_cnt += int'(special_trig === 1'b1);
      adc_cnt += int'(adc_start === 1'b1);
   end

   // Bounded wait for the interrupt line
   task automatic wait_irq(output bit hit);
      hit = 1'b0;
      for (int k = 0; k < 60 && !hit; k++) begin
         @(posedge clock);
         #1;
         hit = (irq === 1'b1);
      end
   endtask

   // One compare run with the timer counting up into the match
   task automatic cmp_run(input logic [3:0] m, input logic p, input logic oe);
      bit hit;
      wr(ccu_pkg::OFS_TIMER_CTRL, 8'h00);
      wr(ccu_pkg::OFS_TIMER_LOW, 8'h10);
      wr(ccu_pkg::OFS_TIMER_HIGH, 8'h01);
      wr(ccu_pkg::OFS_CONTROL, {4'h0, m});
      wr(ccu_pkg::OFS_TIMER_CTRL, 8'h01);
      wait_irq(hit);
      check("irq", {7'h00, hit}, 8'h01);
      check("pin_out", {7'h00, pin_out}, {7'h00, p});
      check("pin_oe_n", {7'h00, pin_oe_n}, {7'h00, oe});
      wr(ccu_pkg::OFS_TIMER_CTRL, 8'h00);
      wr(ccu_pkg::OFS_IRQ_STATUS, 8'h01);
      $display("compare mode %h done", m);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog, far beyond the expected run length
   initial begin
      #400000;
      n_errors++;
      give_verdict();
   end

   // Main sequence
   initial begin
      bit hit;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      rd(ccu_pkg::OFS_CONTROL, 8'h00);
      rd(4'h9, 8'h00);
      wr(ccu_pkg::OFS_TIMER_CTRL, 8'hFC);
      rd(ccu_pkg::OFS_TIMER_CTRL, 8'h00);
      rnd = 8'($random(seed));
      wr(ccu_pkg::OFS_VALUE_LOW, rnd);
      rd(ccu_pkg::OFS_VALUE_LOW, rnd);
      $display("register test done");
      wr(ccu_pkg::OFS_VALUE_LOW, 8'h20);
      wr(ccu_pkg::OFS_VALUE_HIGH, 8'h01);
      wr(ccu_pkg::OFS_IRQ_MASK, 8'h01);
      cmp_run(ccu_pkg::MODE_CMP_SET, 1'b1, 1'b0);
      cmp_run(ccu_pkg::MODE_CMP_CLEAR, 1'b0, 1'b0);
      cmp_run(ccu_pkg::MODE_CMP_TOGGLE, 1'b1, 1'b0);
      cmp_run(ccu_pkg::MODE_CMP_TOGGLE, 1'b0, 1'b0);
      cmp_run(ccu_pkg::MODE_CMP_SET, 1'b1, 1'b0);
      cmp_run(ccu_pkg::MODE_CMP_FLAG, 1'b1, 1'b1);
      cmp_run(ccu_pkg::MODE_CMP_TRIG, 1'b1, 1'b1);
      check("trig pulses", 8'(trig_cnt), 8'h01);
      check("adc pulses", 8'(adc_cnt), 8'h01);
      adc_en <= 1'b0;
      cmp_run(ccu_pkg::MODE_CMP_TRIG, 1'b1, 1'b1);
      check("trig pulses", 8'(trig_cnt), 8'h02);
      check("adc pulses", 8'(adc_cnt), 8'h01);
      rd(ccu_pkg::OFS_TIMER_HIGH, 8'h00);
      wr(ccu_pkg::OFS_CONTROL, 8'h00);
      @(posedge clock);
      #1;
      check("pin_out", {7'h00, pin_out}, 8'h00);
      // Equality by a stopped-timer load must fire only once
      wr(ccu_pkg::OFS_CONTROL, {4'h0, ccu_pkg::MODE_CMP_FLAG});
      wr(ccu_pkg::OFS_TIMER_HIGH, 8'h01);
      wr(ccu_pkg::OFS_TIMER_LOW, 8'h20);
      wait_irq(hit);
      check("irq", {7'h00, hit}, 8'h01);
      wr(ccu_pkg::OFS_IRQ_STATUS, 8'h01);
      repeat (8) @(posedge clock);
      #1;
      check("irq refire", {7'h00, irq}, 8'h00);
      $display("compare tests done");
      // Sleep with instruction clock: timer holds, then resumes on wake
      wr(ccu_pkg::OFS_TIMER_LOW, 8'h40);
      wr(ccu_pkg::OFS_TIMER_HIGH, 8'h00);
      @(posedge clock);
      sleep <= 1'b1;
      wr(ccu_pkg::OFS_TIMER_CTRL, 8'h01);
      repeat (10) @(posedge clock);
      rd(ccu_pkg::OFS_TIMER_LOW, 8'h40);
      sleep <= 1'b0;
      rd(ccu_pkg::OFS_TIMER_LOW, 8'h41);
      sleep <= 1'b1;
      wr(ccu_pkg::OFS_TIMER_LOW, 8'h00);
      // Sleep with external clock: five ticks, then a rising pin captures
      wr(ccu_pkg::OFS_CONTROL, {4'h0, ccu_pkg::MODE_CAP_RISE});
      wr(ccu_pkg::OFS_TIMER_CTRL, 8'h03);
      repeat (5) begin
         @(posedge clock);
         pulse_req <= 1'b1;
         @(posedge clock);
         pulse_req <= 1'b0;
         @(posedge clock);
      end
      repeat (3) @(posedge clock);
      pin_req <= 1'b1;
      repeat (4) @(posedge clock);
      sleep <= 1'b0;
      rd(ccu_pkg::OFS_VALUE_LOW, 8'h05);
      rd(ccu_pkg::OFS_IRQ_STATUS, 8'h01);
      // Falling edge captures a freshly loaded count
      wr(ccu_pkg::OFS_CONTROL, {4'h0, ccu_pkg::MODE_CAP_FALL});
      wr(ccu_pkg::OFS_TIMER_LOW, 8'h33);
      pin_req <= 1'b0;
      repeat (3) @(posedge clock);
      rd(ccu_pkg::OFS_VALUE_LOW, 8'h33);
      repeat (3) @(posedge clock);
      $display("capture tests done");
      give_verdict();
   end
endmodule
